/* File: design/charger_defines.svh */
// Timing counts and encodings for the charger status supervisor
`ifndef CHARGER_DEFINES_SVH
`define CHARGER_DEFINES_SVH

`define CLK_PERIOD_NS          40
`define REQUEST_LOW_TIME_NS    200
`define REQUEST_LOW_CYCLES     ((`REQUEST_LOW_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REQUEST_MAX_CYCLES     250
`define REPORT_DELAY_CYCLES    25
`define REPORT_HALF_CYCLES     25
`define FLASH_HALF_CYCLES      6250000

`define CODE_DIE_HOT           5'h01
`define CODE_BATT_TEMP         5'h02
`define CODE_OVERVOLT          5'h03
`define CODE_HIGH_BASE         5'h0D
`define CODE_LOW_BASE          5'h12
`define CODE_REPORT_ERROR      5'h17

`endif

/* File: design/charger_pkg.sv */
// Types shared by the charger status supervisor
package charger_pkg;

   typedef enum logic [2:0] {
      PH_SLEEP,
      PH_PRECOND,
      PH_CC,
      PH_CV,
      PH_DONE,
      PH_FAULT
   } phase_t;

   typedef struct packed {
      logic supply_ok;
      logic supply_above_reduction;
      logic battery_present;
      logic batt_above_precond;
      logic batt_at_regulation;
      logic batt_above_overvoltage;
      logic batt_below_recharge;
      logic current_below_term;
      logic thermistor_above_low;
      logic thermistor_below_high;
      logic die_over_temp;
   } sense_t;

   typedef struct packed {
      logic die_hot;
      logic batt_temp;
      logic overvolt;
   } fault_t;

endpackage

/* File: design/charger_status_supervisor.sv */
// Charger supervisor: phase control, faults, LEDs and status reply
`timescale 1ns/10ps
`default_nettype none
`include "charger_defines.svh"
module charger_status_supervisor
   import charger_pkg::*;
#(
   parameter int FLASH_HALF = `FLASH_HALF_CYCLES,
   parameter int REQ_MAX    = `REQUEST_MAX_CYCLES,
   parameter int DELAY      = `REPORT_DELAY_CYCLES,
   parameter int HALF       = `REPORT_HALF_CYCLES
)(
   input  wire logic    clk,
   input  wire logic    reset_n,
   input  wire logic    charge_enable,
   input  wire logic    charge_level_select,
   input  wire sense_t  sense,
   input  wire logic    data_in,
   output logic         data_out,
   output logic         data_oe,
   output logic         status_output_a_out,
   output logic         status_output_a_oe,
   output logic         status_output_b_out,
   output logic         status_output_b_oe,
   output logic         pass_enable,
   output logic         high_charge_level,
   output logic         low_charge_level,
   output logic         precondition_current,
   output logic         charge_reduction,
   output phase_t       phase,
   output fault_t       faults
);
   initial
   begin
      if (FLASH_HALF < 1)
         $error("charger_status_supervisor: FLASH_HALF must be positive");
      // The reporter counts in 16 bits; longer spans would be cut to their low 16 bits
      if (REQ_MAX <= `REQUEST_LOW_CYCLES || REQ_MAX > 65535)
         $error("charger_status_supervisor: REQ_MAX out of range");
      if (DELAY < 1 || DELAY > 65535)
         $error("charger_status_supervisor: DELAY out of range");
      if (HALF < 1 || HALF > 65535)
         $error("charger_status_supervisor: HALF out of range");
   end

   phase_t      phase_reg;
   phase_t      phase_next;
   fault_t      fault_now;
   logic        thermistor_ok;
   logic        any_fault;
   logic        reduction_now;
   logic        flash_reg;
   logic [31:0] flash_cnt_reg;
   logic [4:0]  code_now;
   logic        reply_oe;
   logic        reply_busy;

   // Fresh start phase chosen from cell voltage alone
   function automatic phase_t entry_phase(input sense_t s);
      if (!s.batt_above_precond)
         entry_phase = PH_PRECOND;
      else if (!s.batt_at_regulation)
         entry_phase = PH_CC;
      else
         entry_phase = PH_CV;
   endfunction

   // Phase offset inside a report block
   function automatic logic [4:0] phase_offset(input phase_t p, input logic r);
      unique case (p)
         PH_PRECOND: phase_offset = 5'h00;
         PH_CC:      phase_offset = r ? 5'h01 : 5'h02;
         PH_CV:      phase_offset = 5'h03;
         PH_DONE:    phase_offset = 5'h04;
         default:    phase_offset = 5'h1F;
      endcase
   endfunction

   // Supply and enable gate the phase, pass element and LEDs
   function automatic logic charge_allowed(input logic en, input sense_t s);
      charge_allowed = en && s.supply_ok;
   endfunction

   // Phases in which the pass element conducts
   function automatic logic phase_draws_current(input phase_t p);
      unique case (p)
         PH_PRECOND, PH_CC, PH_CV: phase_draws_current = 1'b1;
         default:                  phase_draws_current = 1'b0;
      endcase
   endfunction

   // Reply code: faults first, then level block plus phase offset
   function automatic logic [4:0] report_code(input fault_t f,
                                              input phase_t p,
                                              input logic   r,
                                              input logic   hi);
      logic [4:0] off;
      off = phase_offset(p, r);
      if (f.die_hot)
         report_code = `CODE_DIE_HOT;
      else if (f.batt_temp)
         report_code = `CODE_BATT_TEMP;
      else if (f.overvolt)
         report_code = `CODE_OVERVOLT;
      else if (off == 5'h1F)
         report_code = `CODE_REPORT_ERROR;
      else if (hi)
         report_code = `CODE_HIGH_BASE + off;
      else
         report_code = `CODE_LOW_BASE + off;
   endfunction

   assign thermistor_ok = sense.thermistor_above_low
                          && sense.thermistor_below_high;
   assign fault_now.die_hot   = sense.die_over_temp;
   assign fault_now.batt_temp = !thermistor_ok;
   assign fault_now.overvolt  = sense.batt_above_overvoltage;
   assign any_fault = fault_now.die_hot || fault_now.batt_temp
                      || fault_now.overvolt;
   assign reduction_now = !sense.supply_above_reduction;

   always_comb
   begin
      phase_next = phase_reg;
      if (!charge_allowed(charge_enable, sense))
         phase_next = PH_SLEEP;
      else if (any_fault)
         phase_next = PH_FAULT;
      else
      begin
         unique case (phase_reg)
            PH_SLEEP, PH_FAULT:
               // Every restart reassesses the cell from scratch
               phase_next = sense.battery_present
                            ? entry_phase(sense) : PH_SLEEP;
            PH_PRECOND:
               if (sense.batt_above_precond)
                  phase_next = PH_CC;
            PH_CC:
               if (sense.batt_at_regulation)
                  phase_next = PH_CV;
            PH_CV:
               if (sense.current_below_term)
                  phase_next = PH_DONE;
            PH_DONE:
               if (sense.batt_below_recharge)
                  phase_next = entry_phase(sense);
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         phase_reg <= PH_SLEEP;
      else
         phase_reg <= phase_next;
   end

   // Pass element conducts only in a charging phase
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         pass_enable <= 1'b0;
      else
         pass_enable <= phase_draws_current(phase_next);
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         high_charge_level <= 1'b0;
         low_charge_level  <= 1'b0;
      end
      else
      begin
         high_charge_level <= charge_level_select;
         low_charge_level  <= !charge_level_select;
      end
   end

   // Analog side scales the trickle current from this flag
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         precondition_current <= 1'b0;
      else
         precondition_current <= (phase_next == PH_PRECOND);
   end

   // Reduction only matters while fast charge current flows
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         charge_reduction <= 1'b0;
      else
         charge_reduction <= reduction_now
                             && (phase_next == PH_CC);
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         phase <= PH_SLEEP;
      else
         phase <= phase_next;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         faults <= '0;
      else
         faults <= fault_now;
   end

   // Divider for the no-battery blink; rate is fixed, not capacitor-set
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         flash_cnt_reg <= 32'h00000000;
         flash_reg     <= 1'b0;
      end
      else if (flash_cnt_reg + 32'h00000001 >= 32'(FLASH_HALF))
      begin
         flash_cnt_reg <= 32'h00000000;
         flash_reg     <= !flash_reg;
      end
      else
         flash_cnt_reg <= flash_cnt_reg + 32'h00000001;
   end

   // Open-drain: drive low when on, release when off
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         status_output_a_out <= 1'b0;
         status_output_a_oe  <= 1'b0;
         status_output_b_out <= 1'b0;
         status_output_b_oe  <= 1'b0;
      end
      else
      begin
         status_output_a_out <= 1'b0;
         status_output_b_out <= 1'b0;
         if (!charge_allowed(charge_enable, sense))
         begin
            status_output_a_oe <= 1'b0;
            status_output_b_oe <= 1'b0;
         end
         else if (any_fault)
         begin
            status_output_a_oe <= 1'b1;
            status_output_b_oe <= 1'b1;
         end
         else if (!sense.battery_present)
         begin
            status_output_a_oe <= flash_reg;
            status_output_b_oe <= flash_reg;
         end
         else if (phase_reg == PH_DONE)
         begin
            status_output_a_oe <= 1'b0;
            status_output_b_oe <= 1'b1;
         end
         else if (phase_reg == PH_SLEEP)
         begin
            status_output_a_oe <= 1'b0;
            status_output_b_oe <= 1'b0;
         end
         else
         begin
            status_output_a_oe <= 1'b1;
            status_output_b_oe <= 1'b0;
         end
      end
   end

   // Die heat outranks battery temp outranks over-voltage
   assign code_now = report_code(fault_now, phase_reg, reduction_now,
                                 charge_level_select);

   status_reporter #(
      .REQ_MIN (`REQUEST_LOW_CYCLES),
      .REQ_MAX (REQ_MAX),
      .DELAY   (DELAY),
      .HALF    (HALF)
   ) reporter (
      .clk     (clk),
      .reset_n (reset_n),
      .line_in (data_in),
      .code_in (code_now),
      .line_oe (reply_oe),
      .busy    (reply_busy)
   );

   // The line is only ever sunk; the pull-up makes every high
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         data_out <= 1'b0;
      else
         data_out <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         data_oe <= 1'b0;
      else
         data_oe <= reply_oe && reply_busy;
   end
endmodule // charger_status_supervisor
`default_nettype wire

/* File: design/status_reporter.sv */
// Single-wire status reply engine: request detect and pulse train
`timescale 1ns/10ps
`default_nettype none
`include "charger_defines.svh"
module status_reporter
   import charger_pkg::*;
#(
   parameter int REQ_MIN    = `REQUEST_LOW_CYCLES,
   parameter int REQ_MAX    = `REQUEST_MAX_CYCLES,
   parameter int DELAY      = `REPORT_DELAY_CYCLES,
   parameter int HALF       = `REPORT_HALF_CYCLES
)(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       line_in,
   input  wire logic [4:0] code_in,
   output logic            line_oe,
   output logic            busy
);
   initial
   begin
      if (REQ_MIN < 1 || REQ_MAX <= REQ_MIN || DELAY < 1 || HALF < 1)
         $error("status_reporter: bad timing parameters");
   end

   typedef enum logic [1:0] {R_IDLE, R_REQ, R_WAIT, R_SEND} rstate_t;
   rstate_t     state_reg;
   logic [15:0] cnt_reg;
   logic [4:0]  code_reg;
   logic [4:0]  left_reg;
   logic        prev_reg;

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         prev_reg <= 1'b1;
      else
         prev_reg <= line_in;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         state_reg <= R_IDLE;
         cnt_reg   <= 16'h0000;
         code_reg  <= 5'h00;
         left_reg  <= 5'h00;
         line_oe   <= 1'b0;
      end
      else
      begin
         unique case (state_reg)
            R_IDLE:
            begin
               cnt_reg <= 16'h0000;
               if (prev_reg && !line_in)
                  state_reg <= R_REQ;
            end
            R_REQ:
            begin
               // Count the low time; release ends the request
               if (line_in)
               begin
                  cnt_reg <= 16'h0000;
                  if (cnt_reg + 16'h0001 >= 16'(REQ_MIN)
                      && cnt_reg < 16'(REQ_MAX))
                  begin
                     code_reg  <= code_in;
                     state_reg <= R_WAIT;
                  end
                  else
                     state_reg <= R_IDLE;
               end
               else if (cnt_reg != 16'hFFFF)
                  cnt_reg <= cnt_reg + 16'h0001;
            end
            R_WAIT:
            begin
               if (cnt_reg + 16'h0001 >= 16'(DELAY))
               begin
                  cnt_reg   <= 16'h0000;
                  left_reg  <= code_reg;
                  line_oe   <= 1'b1;
                  state_reg <= R_SEND;
               end
               else
                  cnt_reg <= cnt_reg + 16'h0001;
            end
            R_SEND:
            begin
               // Line activity here is our own; requests are ignored
               if (cnt_reg + 16'h0001 >= 16'(HALF))
               begin
                  cnt_reg <= 16'h0000;
                  if (line_oe)
                  begin
                     line_oe  <= 1'b0;
                     left_reg <= left_reg - 5'h01;
                  end
                  else if (left_reg == 5'h00)
                     state_reg <= R_IDLE;
                  else
                     line_oe <= 1'b1;
               end
               else
                  cnt_reg <= cnt_reg + 16'h0001;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         busy <= 1'b0;
      else
         busy <= (state_reg == R_WAIT) || (state_reg == R_SEND);
   end
endmodule // status_reporter
`default_nettype wire

/* File: verification/charger_status_supervisor_checker.sv */
// Port assertions for the charger status supervisor
`timescale 1ns/10ps
`default_nettype none
module charger_status_supervisor_checker
   import charger_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   reset_n,
   input  wire logic   charge_enable,
   input  wire logic   charge_level_select,
   input  wire sense_t sense,
   input  wire logic   data_in,
   input  wire logic   data_out,
   input  wire logic   data_oe,
   input  wire logic   status_output_a_out,
   input  wire logic   status_output_a_oe,
   input  wire logic   status_output_b_out,
   input  wire logic   status_output_b_oe,
   input  wire logic   pass_enable,
   input  wire logic   high_charge_level,
   input  wire logic   low_charge_level,
   input  wire phase_t phase
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // Host pulls the line while the device is quiet, then lets go
   sequence req_end;
      (!data_in && !data_oe) [*5] ##1 (data_in && !data_oe);
   endsequence
   sequence die_fault_held;
      (charge_enable && sense.supply_ok && sense.die_over_temp) [*2];
   endsequence
   a_off_sleeps: assert property (
      !charge_enable |=> phase == PH_SLEEP && !pass_enable)
      else $error("charging while disabled");
   a_level_follows: assert property (
      charge_level_select |=> high_charge_level && !low_charge_level)
      else $error("high level not selected");
   a_overvolt_stop: assert property (
      sense.batt_above_overvoltage |=> !pass_enable)
      else $error("pass element on above overvoltage");
   a_die_hot_stop: assert property (
      sense.die_over_temp |=> !pass_enable)
      else $error("pass element on with hot die");
   a_cold_therm_stop: assert property (
      !sense.thermistor_above_low |=> !pass_enable)
      else $error("pass element on below thermistor window");
   a_fault_leds_on: assert property (
      die_fault_held |=> status_output_a_oe && status_output_b_oe)
      else $error("fault not shown on both outputs");
   a_off_leds_dark: assert property (
      !charge_enable [*2] |=> !status_output_a_oe && !status_output_b_oe)
      else $error("outputs lit while disabled");
   a_leds_sink_only: assert property (
      status_output_a_oe || status_output_b_oe
         |-> !status_output_a_out && !status_output_b_out)
      else $error("status output driven high");
   a_line_low_only: assert property (
      data_oe |-> !data_out)
      else $error("data line driven high");
   a_reply_waits: assert property (
      req_end |-> !data_oe [*8])
      else $error("reply started without delay");
   a_reply_starts: assert property (
      req_end |-> ##[20:40] data_oe)
      else $error("no reply after request");
   a_pulse_width: assert property (
      $rose(data_oe) |-> ##24 data_oe ##1 !data_oe)
      else $error("reply pulse width wrong");
endmodule // charger_status_supervisor_checker
`default_nettype wire

/* File: verification/charger_status_supervisor_tb_top.sv */
// Self-checking bench for the charger status supervisor
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
   $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module charger_status_supervisor_tb_top
   import charger_pkg::*;
;
   localparam sense_t GOOD = 11'h706;
   logic       clk = 1'b0;
   logic       reset_n = 1'b0;
   logic       en = 1'b0;
   logic       sel = 1'b0;
   sense_t     s = GOOD;
   logic       req = 1'b0;
   logic [7:0] len = 8'h06;
   logic       line, host_oe, done, data_out, data_oe, pass, hi, lo;
   logic       a_out, a_oe, b_out, b_oe, pre, red;
   logic [5:0] count;
   phase_t     phase;
   fault_t     faults;
   int         n_fail = 0;
   int         n_tests = 0;
   always #20 clk = ~clk;
   // Pull-up wins unless someone sinks the line
   assign line = !(data_oe | host_oe);
   charger_status_supervisor #(.FLASH_HALF(4)) dut_u (
      .clk, .reset_n, .charge_enable(en), .charge_level_select(sel),
      .sense(s), .data_in(line), .data_out, .data_oe,
      .status_output_a_out(a_out), .status_output_a_oe(a_oe),
      .status_output_b_out(b_out), .status_output_b_oe(b_oe),
      .pass_enable(pass), .high_charge_level(hi), .low_charge_level(lo),
      .precondition_current(pre), .charge_reduction(red), .phase, .faults);
   host_model host_u (.clk, .reset_n, .req, .low_len(len), .line,
      .line_oe(host_oe), .count, .done);
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask
   task automatic results;
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic ask(input logic [7:0] n, input logic [5:0] e);
      len = n;
      req = 1'b1;
      cyc(1);
      req = 1'b0;
      cyc(2);
      for (int i = 0; i < 3000 && done !== 1'b1; i++)
         cyc(1);
      `CHK("reply count", e, count)
   endtask
   task automatic t_sleep;
      en = 1'b0;
      s = GOOD;
      cyc(3);
      `CHK("off state", 3'b000, {pass, a_oe, b_oe})
      ask(8'h06, 6'h17);
      en = 1'b1;
      s.supply_ok = 1'b0;
      cyc(3);
      `CHK("uvlo", 3'b000, {pass, a_oe, b_oe})
      s.supply_ok = 1'b1;
      cyc(3);
      `CHK("resume", PH_PRECOND, phase)
      ask(8'h03, 6'h00);
   endtask
   task automatic t_phases;
      logic [5:0] b;
      for (int k = 0; k < 2; k++)
      begin
         sel = (k == 0);
         b = sel ? 6'h0D : 6'h12;
         en = 1'b0;
         s = GOOD;
         cyc(2);
         en = 1'b1;
         cyc(3);
         `CHK("level", {sel, !sel}, {hi, lo})
         `CHK("precond", 2'b11, {pre, pass})
         `CHK("charging leds", 2'b10, {a_oe, b_oe})
         ask(8'h06, b);
         s.batt_above_precond = 1'b1;
         s.supply_above_reduction = 1'b0;
         cyc(3);
         `CHK("reduce", 1'b1, red)
         ask(8'h06, b + 6'h01);
         s.supply_above_reduction = 1'b1;
         cyc(3);
         ask(8'h06, b + 6'h02);
         s.batt_at_regulation = 1'b1;
         cyc(3);
         ask(8'h06, b + 6'h03);
         s.current_below_term = 1'b1;
         cyc(3);
         `CHK("done", 3'b001, {pass, a_oe, b_oe})
         ask(8'h06, b + 6'h04);
         s.current_below_term = 1'b0;
         s.batt_below_recharge = 1'b1;
         cyc(3);
         `CHK("recharge", PH_CV, phase)
      end
   endtask
   task automatic t_faults;
      for (int i = 0; i < 3; i++)
      begin
         s = GOOD;
         s.batt_above_precond = 1'b1;
         cyc(3);
         s.die_over_temp = (i == 0);
         s.thermistor_above_low = (i != 1);
         s.batt_above_overvoltage = (i == 2);
         cyc(3);
         `CHK("fault phase", PH_FAULT, phase)
         `CHK("fault out", 3'b011, {pass, a_oe, b_oe})
         `CHK("fault kind", fault_t'(3'h4 >> i), faults)
         ask(8'h06, 6'(i + 1));
         s = GOOD;
         s.batt_above_precond = 1'b1;
         cyc(3);
         `CHK("recover", 1'b1, pass)
      end
   endtask
   task automatic t_flash;
      int ons;
      int odd;
      ons = 0;
      odd = 0;
      s = GOOD;
      s.battery_present = 1'b0;
      cyc(3);
      repeat (16)
      begin
         ons += (a_oe === 1'b1);
         odd += (a_oe !== b_oe);
         cyc(1);
      end
      `CHK("flash apart", 0, odd)
      `CHK("flash on", 8, ons)
      `CHK("sink only", 3'b000, {data_out, a_out, b_out})
   endtask
   initial
   begin
      cyc(12);
      reset_n = 1'b1;
      cyc(2);
      t_sleep();
      t_phases();
      t_faults();
      t_flash();
      results();
   end
   // Longest path is about 15000 cycles of replies
   initial
   begin
      repeat (60000) @(posedge clk);
      n_fail++;
      results();
   end
endmodule // charger_status_supervisor_tb_top
bind charger_status_supervisor charger_status_supervisor_checker chk_u (
   .clk, .reset_n, .charge_enable, .charge_level_select, .sense, .data_in,
   .data_out, .data_oe, .status_output_a_out, .status_output_a_oe,
   .status_output_b_out, .status_output_b_oe, .pass_enable,
   .high_charge_level, .low_charge_level, .phase);
`default_nettype wire

/* File: verification/host_model.sv */
// Host microcontroller model: request pulse and reply pulse counter
`timescale 1ns/10ps
`default_nettype none
module host_model (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       req,
   input  wire logic [7:0] low_len,
   input  wire logic       line,
   output logic            line_oe,
   output logic [5:0]      count,
   output logic            done
);
   logic [7:0] drive_reg;
   logic [8:0] idle_reg;
   logic       line_reg;
   // Only sinks the line; callers keep low_len below the maximum
   assign line_oe = (drive_reg != 8'h00);
   always_ff @(posedge clk)
   begin
      line_reg <= line;
      if (!reset_n || req)
      begin
         drive_reg <= reset_n ? low_len : 8'h00;
         idle_reg  <= 9'h000;
         count     <= 6'h00;
         done      <= 1'b0;
      end
      else if (drive_reg != 8'h00)
         drive_reg <= drive_reg - 8'h01;
      else if (line_reg && !line)
      begin
         count    <= count + 6'h01;
         idle_reg <= 9'h000;
      end
      else if (idle_reg == 9'h12C)
         done <= 1'b1;
      else
         idle_reg <= idle_reg + 9'h001;
   end
endmodule // host_model
`default_nettype wire
